// File: common/shc_defines.svh
// register offsets, field positions, reset values and scale figures
`ifndef SHC_DEFINES_SVH
`define SHC_DEFINES_SVH
`define SHC_ADDR_ANT1_DEEP 8'h63
`define SHC_ADDR_ANT2_PROX 8'h81
`define SHC_ADDR_ANT2_TOUCH 8'h82
`define SHC_ADDR_ANT2_DEEP 8'h83
`define SHC_ADDR_HALL_FE 8'h90
`define SHC_ADDR_HALL_TUNE 8'h91
`define SHC_ADDR_COMP_LO 8'h92
`define SHC_ADDR_COMP_HI 8'h93
`define SHC_RST_ZERO 8'h00
`define SHC_RST_HALL_FE 8'h03
`define SHC_RST_HALL_TUNE 8'h50
`define SHC_MASK_ALL 8'hFF
`define SHC_MASK_HALL_FE 8'h33
`define SHC_FE_DIV_HI 5
`define SHC_FE_DIV_LO 4
`define SHC_FE_MODE_HI 1
`define SHC_FE_MODE_LO 0
`define SHC_TUNE_BASE_HI 7
`define SHC_TUNE_BASE_LO 6
`define SHC_TUNE_TGT_HI 5
`define SHC_TUNE_TGT_LO 0
`define SHC_MUL_COMP_HI 7
`define SHC_MUL_COMP_LO 6
`define SHC_MUL_COARSE_HI 5
`define SHC_MUL_COARSE_LO 4
`define SHC_MUL_FINE_HI 3
`define SHC_MUL_FINE_LO 0
`define SHC_BASE_75 8'h4B
`define SHC_BASE_100 8'h64
`define SHC_BASE_150 8'h96
`define SHC_BASE_200 8'hC8
`define SHC_DIV_MIN 5'h02
`define SHC_TGT_SHIFT 5
`define SHC_DEEP2_SHIFT 2
`define SHC_AVG_SHIFT 8
`define SHC_RST_DIV 5'h02
`define SHC_RST_BASE 8'h64
`define SHC_RST_TGT 11'h200
`endif

// File: common/shc_pkg.sv
// types shared by the sensor configuration register bank
package shc_pkg;
  typedef enum logic [1:0] {SHC_TUNE_OFF, SHC_TUNE_PARTIAL, SHC_TUNE_SEMI, SHC_TUNE_FULL} shc_tune_mode_type;
endpackage

// File: common/shc_hall_if.sv
// raw hall settings bytes out, decoded hall fields back
`timescale 1ns/1ps
interface shc_hall_if;
  import shc_pkg::*;
  logic [7:0] fe;
  logic [7:0] tune;
  logic [7:0] comp_lo;
  logic [7:0] comp_hi;
  logic [4:0] div;
  shc_tune_mode_type mode;
  logic tune_en;
  logic coarse_fix;
  logic fine_fix;
  logic [7:0] base;
  logic [10:0] target;
  logic [9:0] comp;
  logic [1:0] coarse;
  logic [3:0] fine;
  modport regs (output fe, tune, comp_lo, comp_hi,
    input div, mode, tune_en, coarse_fix, fine_fix, base, target, comp, coarse, fine);
  modport dec (input fe, tune, comp_lo, comp_hi,
    output div, mode, tune_en, coarse_fix, fine_fix, base, target, comp, coarse, fine);
endinterface

// File: hw/shc_byte_reg.sv
// one software-writable configuration byte with masked bits
`timescale 1ns/1ps
`include "shc_defines.svh"
module shc_byte_reg #(
  parameter logic [7:0] RST_VAL = `SHC_RST_ZERO,
  parameter logic [7:0] WR_MASK = `SHC_MASK_ALL
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  // masked positions never store, so they read back as zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= RST_VAL & WR_MASK;
    else if (wr_en)
      q <= wdata & WR_MASK;
  end
endmodule

// File: hw/shc_hall_decode.sv
// decodes hall front-end, tuning and multiplier fields
`timescale 1ns/1ps
`include "shc_defines.svh"
module shc_hall_decode
  import shc_pkg::*;
(
  shc_hall_if.dec hif
);
  logic [1:0] mode_bits;
  assign mode_bits = hif.fe[`SHC_FE_MODE_HI:`SHC_FE_MODE_LO];
  assign hif.div = `SHC_DIV_MIN << hif.fe[`SHC_FE_DIV_HI:`SHC_FE_DIV_LO];
  assign hif.target = {5'h00, hif.tune[`SHC_TUNE_TGT_HI:`SHC_TUNE_TGT_LO]} << `SHC_TGT_SHIFT;
  assign hif.comp = {hif.comp_hi[`SHC_MUL_COMP_HI:`SHC_MUL_COMP_LO], hif.comp_lo};
  assign hif.coarse = hif.comp_hi[`SHC_MUL_COARSE_HI:`SHC_MUL_COARSE_LO];
  assign hif.fine = hif.comp_hi[`SHC_MUL_FINE_HI:`SHC_MUL_FINE_LO];
  always_comb
  begin
    hif.mode = shc_tune_mode_type'(mode_bits);
    hif.tune_en = 1'b1;
    hif.coarse_fix = 1'b0;
    hif.fine_fix = 1'b0;
    // off holds both multipliers so nothing drifts
    case (hif.mode)
      SHC_TUNE_OFF:
      begin
        hif.tune_en = 1'b0;
        hif.coarse_fix = 1'b1;
        hif.fine_fix = 1'b1;
      end
      SHC_TUNE_PARTIAL:
      begin
        hif.coarse_fix = 1'b1;
        hif.fine_fix = 1'b1;
      end
      SHC_TUNE_SEMI: hif.coarse_fix = 1'b1;
      default: hif.tune_en = 1'b1;
    endcase
  end
  always_comb
  begin
    case (hif.tune[`SHC_TUNE_BASE_HI:`SHC_TUNE_BASE_LO])
      2'h0: hif.base = `SHC_BASE_75;
      2'h1: hif.base = `SHC_BASE_100;
      2'h2: hif.base = `SHC_BASE_150;
      default: hif.base = `SHC_BASE_200;
    endcase
  end
endmodule

// File: hw/shc_config_regs.sv
// SAR threshold and hall front-end configuration register bank
// Notes on behaviour
// - ant1 deep threshold is value times average/256
// - ant2 proximity threshold used directly, 0-255
// - ant2 touch threshold used directly, 0-255
// - ant2 deep threshold is value times four
// - hall divider field selects 2,4,8,16
// - tuning mode: off, partial, semi, full
// - tuning base field selects 75,100,150,200
// - tuning target is six-bit field times 32
// - compensation is ten bits over two bytes
// - coarse and fine multipliers from 0x93
`timescale 1ns/1ps
`include "shc_defines.svh"
module shc_config_regs
  import shc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] long_term_average,
  output logic [15:0] ant1_deep_thr,
  output logic [7:0] ant2_prox_thr,
  output logic [7:0] ant2_touch_thr,
  output logic [9:0] ant2_deep_thr,
  output logic [4:0] charge_clock_divider,
  output shc_tune_mode_type auto_tuning_mode,
  output logic tuning_enable,
  output logic coarse_mult_fixed,
  output logic fine_mult_fixed,
  output logic [7:0] tuning_base,
  output logic [10:0] tuning_target,
  output logic [9:0] compensation,
  output logic [1:0] coarse_mult,
  output logic [3:0] fine_mult
);
  logic hit_a1d;
  logic hit_a2p;
  logic hit_a2t;
  logic hit_a2d;
  logic hit_fe;
  logic hit_tune;
  logic hit_clo;
  logic hit_chi;
  logic [7:0] a1d_q;
  logic [7:0] a2p_q;
  logic [7:0] a2t_q;
  logic [7:0] a2d_q;
  logic [7:0] rdata_nxt;
  logic [23:0] a1d_prod;
  shc_hall_if hif ();

  assign hit_a1d = reg_wr && (reg_addr == `SHC_ADDR_ANT1_DEEP);
  assign hit_a2p = reg_wr && (reg_addr == `SHC_ADDR_ANT2_PROX);
  assign hit_a2t = reg_wr && (reg_addr == `SHC_ADDR_ANT2_TOUCH);
  assign hit_a2d = reg_wr && (reg_addr == `SHC_ADDR_ANT2_DEEP);
  assign hit_fe = reg_wr && (reg_addr == `SHC_ADDR_HALL_FE);
  assign hit_tune = reg_wr && (reg_addr == `SHC_ADDR_HALL_TUNE);
  assign hit_clo = reg_wr && (reg_addr == `SHC_ADDR_COMP_LO);
  assign hit_chi = reg_wr && (reg_addr == `SHC_ADDR_COMP_HI);

  shc_byte_reg u_a1d (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_a1d),
    .wdata(reg_wdata),
    .q(a1d_q)
  );
  shc_byte_reg u_a2p (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_a2p),
    .wdata(reg_wdata),
    .q(a2p_q)
  );
  shc_byte_reg u_a2t (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_a2t),
    .wdata(reg_wdata),
    .q(a2t_q)
  );
  shc_byte_reg u_a2d (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_a2d),
    .wdata(reg_wdata),
    .q(a2d_q)
  );
  shc_byte_reg #(
    .RST_VAL(`SHC_RST_HALL_FE),
    .WR_MASK(`SHC_MASK_HALL_FE)
  ) u_fe (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_fe),
    .wdata(reg_wdata),
    .q(hif.fe)
  );
  shc_byte_reg #(
    .RST_VAL(`SHC_RST_HALL_TUNE)
  ) u_tune (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_tune),
    .wdata(reg_wdata),
    .q(hif.tune)
  );
  shc_byte_reg u_clo (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_clo),
    .wdata(reg_wdata),
    .q(hif.comp_lo)
  );
  shc_byte_reg u_chi (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(hit_chi),
    .wdata(reg_wdata),
    .q(hif.comp_hi)
  );

  shc_hall_decode u_dec (
    .hif(hif)
  );

  // unmapped offsets read zero so software can probe safely
  always_comb
  begin
    case (reg_addr)
      `SHC_ADDR_ANT1_DEEP: rdata_nxt = a1d_q;
      `SHC_ADDR_ANT2_PROX: rdata_nxt = a2p_q;
      `SHC_ADDR_ANT2_TOUCH: rdata_nxt = a2t_q;
      `SHC_ADDR_ANT2_DEEP: rdata_nxt = a2d_q;
      `SHC_ADDR_HALL_FE: rdata_nxt = hif.fe;
      `SHC_ADDR_HALL_TUNE: rdata_nxt = hif.tune;
      `SHC_ADDR_COMP_LO: rdata_nxt = hif.comp_lo;
      `SHC_ADDR_COMP_HI: rdata_nxt = hif.comp_hi;
      default: rdata_nxt = `SHC_RST_ZERO;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `SHC_RST_ZERO;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= `SHC_RST_ZERO;
  end

  // average may move every cycle, so the scaled value tracks it
  assign a1d_prod = {8'h00, a1d_q} * {8'h00, long_term_average};

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ant1_deep_thr <= 16'h0000;
    else
      ant1_deep_thr <= a1d_prod[23:`SHC_AVG_SHIFT];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ant2_prox_thr <= `SHC_RST_ZERO;
      ant2_touch_thr <= `SHC_RST_ZERO;
      ant2_deep_thr <= 10'h000;
    end
    else
    begin
      ant2_prox_thr <= a2p_q;
      ant2_touch_thr <= a2t_q;
      ant2_deep_thr <= {a2d_q, 2'h0};
    end
  end

  // reset images match the decoded defaults of the hall bytes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      charge_clock_divider <= `SHC_RST_DIV;
      auto_tuning_mode <= SHC_TUNE_FULL;
      tuning_enable <= 1'b1;
      coarse_mult_fixed <= 1'b0;
      fine_mult_fixed <= 1'b0;
      tuning_base <= `SHC_RST_BASE;
      tuning_target <= `SHC_RST_TGT;
    end
    else
    begin
      charge_clock_divider <= hif.div;
      auto_tuning_mode <= hif.mode;
      tuning_enable <= hif.tune_en;
      coarse_mult_fixed <= hif.coarse_fix;
      fine_mult_fixed <= hif.fine_fix;
      tuning_base <= hif.base;
      tuning_target <= hif.target;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      compensation <= 10'h000;
      coarse_mult <= 2'h0;
      fine_mult <= 4'h0;
    end
    else
    begin
      compensation <= hif.comp;
      coarse_mult <= hif.coarse;
      fine_mult <= hif.fine;
    end
  end

  property p_a1d_scale;
    @(posedge core_clk) disable iff (rst)
    hit_a1d ##1 !hit_a1d |=>
      ant1_deep_thr == 16'((24'($past(reg_wdata, 2)) * 24'($past(long_term_average))) >> 8);
  endproperty
  a_a1d_scale: assert property (p_a1d_scale) else $error("ant1 deep threshold wrong");

  property p_a2p;
    @(posedge core_clk) disable iff (rst)
    hit_a2p ##1 !hit_a2p |=> ant2_prox_thr == $past(reg_wdata, 2);
  endproperty
  a_a2p: assert property (p_a2p) else $error("ant2 prox threshold wrong");

  property p_a2t;
    @(posedge core_clk) disable iff (rst)
    hit_a2t |-> ##2 ant2_touch_thr == $past(reg_wdata, 2) || $past(hit_a2t);
  endproperty
  a_a2t: assert property (p_a2t) else $error("ant2 touch threshold wrong");

  property p_a2d;
    @(posedge core_clk) disable iff (rst)
    hit_a2d ##1 !hit_a2d |=> ant2_deep_thr == {$past(reg_wdata, 2), 2'h0} && ant2_deep_thr[1:0] == 2'h0;
  endproperty
  a_a2d: assert property (p_a2d) else $error("ant2 deep threshold not times four");

  property p_div;
    @(posedge core_clk) disable iff (rst)
    hit_fe ##1 !hit_fe |=> charge_clock_divider == 5'(5'h02 << $past(reg_wdata[5:4], 2));
  endproperty
  a_div: assert property (p_div) else $error("charge divider decode wrong");

  property p_mode;
    @(posedge core_clk) disable iff (rst)
    hit_fe ##1 !hit_fe |=> auto_tuning_mode == shc_tune_mode_type'($past(reg_wdata[1:0], 2))
      && tuning_enable == ($past(reg_wdata[1:0], 2) != 2'h0)
      && coarse_mult_fixed == ($past(reg_wdata[1:0], 2) != 2'h3)
      && fine_mult_fixed == ($past(reg_wdata[1:0], 2) <= 2'h1);
  endproperty
  a_mode: assert property (p_mode) else $error("tuning mode decode wrong");

  property p_base;
    @(posedge core_clk) disable iff (rst)
    hit_tune && reg_wdata[7:6] == 2'h2 ##1 !hit_tune |=> tuning_base == 8'h96;
  endproperty
  a_base: assert property (p_base) else $error("tuning base decode wrong");

  property p_target;
    @(posedge core_clk) disable iff (rst)
    hit_tune ##1 !hit_tune |=> tuning_target == 11'({$past(reg_wdata[5:0], 2), 5'h00});
  endproperty
  a_target: assert property (p_target) else $error("tuning target not times 32");

  property p_comp;
    @(posedge core_clk) disable iff (rst)
    hit_chi ##1 !hit_chi |=> compensation[9:8] == $past(reg_wdata[7:6], 2)
      && compensation[7:0] == $past(hif.comp_lo);
  endproperty
  a_comp: assert property (p_comp) else $error("compensation assembly wrong");

  property p_mult;
    @(posedge core_clk) disable iff (rst)
    hit_chi ##1 !hit_chi |=> coarse_mult == $past(reg_wdata[5:4], 2) && fine_mult == $past(reg_wdata[3:0], 2);
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier fields wrong");

  property p_fe_reserved;
    @(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == `SHC_ADDR_HALL_FE |=> (reg_rdata & 8'hCC) == 8'h00;
  endproperty
  a_fe_reserved: assert property (p_fe_reserved) else $error("reserved hall bits not zero");

  property p_reset_defaults;
    @(posedge core_clk)
    $fell(rst) |-> charge_clock_divider == 5'h02 && auto_tuning_mode == SHC_TUNE_FULL
      && tuning_base == 8'h64 && tuning_target == 11'h200 && ant2_prox_thr == 8'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

  property p_rd_idle;
    @(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  property p_rd_after_wr;
    @(posedge core_clk) disable iff (rst)
    hit_a2p ##1 (reg_rd && reg_addr == `SHC_ADDR_ANT2_PROX) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rd_after_wr: assert property (p_rd_after_wr) else $error("read after write not new value");

  property p_fe_store;
    @(posedge core_clk) disable iff (rst)
    hit_fe |=> (hif.fe & 8'hCC) == 8'h00 && hif.fe[5:4] == $past(reg_wdata[5:4])
      && hif.fe[1:0] == $past(reg_wdata[1:0]);
  endproperty
  a_fe_store: assert property (p_fe_store) else $error("hall settings write not masked");

  property p_mode_flags;
    @(posedge core_clk) disable iff (rst)
    tuning_enable == (auto_tuning_mode != SHC_TUNE_OFF) && (coarse_mult_fixed || !fine_mult_fixed);
  endproperty
  a_mode_flags: assert property (p_mode_flags) else $error("tuning flags disagree with mode");

  // average moves freely, so the scaled value must follow it every cycle
  property p_a1d_track;
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> ant1_deep_thr == 16'((24'($past(a1d_q)) * 24'($past(long_term_average))) >> 8);
  endproperty
  a_a1d_track: assert property (p_a1d_track) else $error("ant1 deep threshold not tracking average");

  property p_unmapped_rd;
    @(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == 8'h94 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    !reg_wr || reg_addr == 8'h94 |=>
      $stable({a1d_q, a2p_q, a2t_q, a2d_q, hif.fe, hif.tune, hif.comp_lo, hif.comp_hi});
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without a write");
endmodule

// File: verification/shc_config_regs_tb_top.sv
// self-checking bench for the sensor configuration register bank
`timescale 1ns/1ps
`include "shc_defines.svh"
module shc_config_regs_tb_top
  import shc_pkg::*;
;
  logic core_clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [15:0] long_term_average;
  logic [15:0] ant1_deep_thr;
  logic [7:0] ant2_prox_thr;
  logic [7:0] ant2_touch_thr;
  logic [9:0] ant2_deep_thr;
  logic [4:0] charge_clock_divider;
  shc_tune_mode_type auto_tuning_mode;
  logic tuning_enable;
  logic coarse_mult_fixed;
  logic fine_mult_fixed;
  logic [7:0] tuning_base;
  logic [10:0] tuning_target;
  logic [9:0] compensation;
  logic [1:0] coarse_mult;
  logic [3:0] fine_mult;
  int fails;
  int checks_done;
  logic [31:0] seed_r;
  logic [7:0] ev [8];
  logic [7:0] addr_t [8];

  shc_config_regs shc_config_regs_inst (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .long_term_average(long_term_average),
    .ant1_deep_thr(ant1_deep_thr),
    .ant2_prox_thr(ant2_prox_thr),
    .ant2_touch_thr(ant2_touch_thr),
    .ant2_deep_thr(ant2_deep_thr),
    .charge_clock_divider(charge_clock_divider),
    .auto_tuning_mode(auto_tuning_mode),
    .tuning_enable(tuning_enable),
    .coarse_mult_fixed(coarse_mult_fixed),
    .fine_mult_fixed(fine_mult_fixed),
    .tuning_base(tuning_base),
    .tuning_target(tuning_target),
    .compensation(compensation),
    .coarse_mult(coarse_mult),
    .fine_mult(fine_mult)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed_r = seed_r ^ (seed_r << 13);
    seed_r = seed_r ^ (seed_r >> 17);
    seed_r = seed_r ^ (seed_r << 5);
    return seed_r;
  endfunction

  function automatic logic [7:0] exp_base(input logic [1:0] c);
    case (c)
      2'h0: return 8'h4B;
      2'h1: return 8'h64;
      2'h2: return 8'h96;
      default: return 8'hC8;
    endcase
  endfunction

  // full 24-bit product, only the upper 16 bits survive the /256
  function automatic logic [15:0] exp_deep(input logic [7:0] v, input logic [15:0] a);
    logic [23:0] p;
    p = v * a;
    return p[23:8];
  endfunction

  function automatic logic [2:0] exp_fix(input logic [1:0] m);
    return {m != 2'h0, m != 2'h3, m < 2'h2};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask

  task automatic idle();
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // strobe is dropped at the take edge, so one idle cycle falls before the next write
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check_all();
    logic [7:0] q;
    rd(8'h94, q);
    chk(q, 16'h0, "unmapped read");
    // last read is a mapped one, so the clear after it can really be seen
    for (int k = 0; k < 8; k++)
    begin
      rd(addr_t[k], q);
      chk(q, (k == 4) ? (ev[k] & 8'h33) : ev[k], "readback");
    end
    @(posedge core_clk);
    #1;
    chk(reg_rdata, 16'h0, "rdata after read");
    chk(ant1_deep_thr, exp_deep(ev[0], long_term_average), "ant1 deep");
    chk(ant2_prox_thr, ev[1], "ant2 prox");
    chk(ant2_touch_thr, ev[2], "ant2 touch");
    chk(ant2_deep_thr, ev[3] * 4, "ant2 deep");
    chk(charge_clock_divider, 2 << ev[4][5:4], "divider");
    chk(auto_tuning_mode, ev[4][1:0], "mode");
    chk({tuning_enable, coarse_mult_fixed, fine_mult_fixed}, exp_fix(ev[4][1:0]), "fixed");
    chk(tuning_base, exp_base(ev[5][7:6]), "base");
    chk(tuning_target, ev[5][5:0] * 32, "target");
    chk(compensation, {ev[7][7:6], ev[6]}, "compensation");
    chk({coarse_mult, fine_mult}, ev[7][5:0], "multipliers");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    long_term_average = 16'h0000;
    seed_r = 32'h37;
    fails = 0;
    checks_done = 0;
    addr_t = '{8'h63, 8'h81, 8'h82, 8'h83, 8'h90, 8'h91, 8'h92, 8'h93};
    ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h50, 8'h00, 8'h00};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    check_all();
    // i walks every divider and mode code; first pass is all-zero, last is all-ones except tuning base bits 7:6 of 0x91, which are zero
    for (int i = 0; i < 16; i++)
    begin
      logic [31:0] r;
      logic [7:0] q;
      for (int k = 0; k < 8; k++)
      begin
        r = rnd();
        ev[k] = (i == 0) ? 8'h00 : (i == 15) ? 8'hFF : r[7:0];
      end
      ev[4] = {ev[4][7:6], i[3:2], ev[4][3:2], i[1:0]};
      ev[5][7:6] = i[1:0] ^ i[3:2];
      for (int k = 0; k < 8; k++)
        wr(addr_t[k], ev[k]);
      // read in the very cycle after the write must already see the new byte
      wr(addr_t[1], ev[1]);
      rd(addr_t[1], q);
      chk(q, ev[1], "read right after write");
      wr(8'h94, r[15:8]);
      long_term_average <= (i == 15) ? 16'hFFFF : r[31:16];
      idle();
      repeat (2) @(posedge core_clk);
      check_all();
    end
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h50, 8'h00, 8'h00};
    check_all();
    summarize();
  end

  // whole run is under a thousand cycles; this allows five thousand
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
endmodule
